// *** rtl/charge_port_ctrl.sv ***
module charge_port_ctrl #( // RULE_22
  parameter int LONG_DISCHARGE_CYCLES = charge_port_pkg::LONG_DISCHARGE_CYC,
  parameter int SHORT_DISCHARGE_CYCLES = charge_port_pkg::SHORT_DISCHARGE_CYC,
  parameter int SCHEME_1V2_CYCLES = charge_port_pkg::SCHEME_1V2_CYC,
  parameter int RETEST_CYCLES = charge_port_pkg::RETEST_CYC,
  parameter int TIMER_W = charge_port_pkg::TIMER_WIDTH
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic mode_select_bit1_i,
  input wire logic mode_select_bit2_i,
  input wire logic mode_select_bit3_i,
  input wire logic current_limit_select_i,
  input wire logic enable_i,
  input wire logic high_current_i,
  input wire logic device_on_lines_i,
  input wire logic current_limit_active_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic power_switch_on_o,
  output logic out_discharge_o,
  output logic data_switch_on_o,
  output logic lines_shorted_o,
  output logic pull_1v2_o,
  output logic divider_a_o,
  output logic divider_b_o
);

  // a timer too narrow would wrap and cut any interval over MAX_COUNT cycles short
  localparam int MAX_COUNT = 2 ** TIMER_W;
  if (TIMER_W < 2 || TIMER_W > 31 ||
      LONG_DISCHARGE_CYCLES < 1 || LONG_DISCHARGE_CYCLES > MAX_COUNT ||
      SHORT_DISCHARGE_CYCLES < 1 || SHORT_DISCHARGE_CYCLES > MAX_COUNT ||
      SCHEME_1V2_CYCLES < 1 || SCHEME_1V2_CYCLES > MAX_COUNT ||
      RETEST_CYCLES < 1 || RETEST_CYCLES > MAX_COUNT) begin : g_bad_param
    $error("charge_port_ctrl: timer parameters out of range");
  end

  localparam logic [TIMER_W-1:0] LONG_LOAD =
    TIMER_W'(LONG_DISCHARGE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SHORT_LOAD =
    TIMER_W'(SHORT_DISCHARGE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] PULL_LOAD = TIMER_W'(SCHEME_1V2_CYCLES - 1);
  localparam logic [TIMER_W-1:0] RETEST_LOAD = TIMER_W'(RETEST_CYCLES - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;

  charge_port_pkg::ctrl_state_t state_reg;
  charge_port_pkg::ctrl_state_t state_next;
  charge_port_pkg::port_mode_t mode_reg;
  charge_port_pkg::port_mode_t mode_next;
  charge_port_pkg::port_mode_t pin_mode;
  charge_port_pkg::ctrl_state_t entry_state;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic disch_req_reg;
  logic disch_req_next;
  logic disch_req_clr;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic power_reg;
  logic disch_out_reg;
  logic data_sw_reg;
  logic shorted_reg;
  logic pull_reg;
  logic div_a_reg;
  logic div_b_reg;

  // pin decode, ordered bit1 bit2 bit3
  wire [2:0] pins = {mode_select_bit1_i, mode_select_bit2_i,
                     mode_select_bit3_i};
  assign pin_mode =
    (pins == 3'h0) ? charge_port_pkg::MODE_DISCHARGE :          // RULE_18
    (pins == 3'h7) ? (current_limit_select_i ?
                      charge_port_pkg::MODE_CDP :
                      charge_port_pkg::MODE_STANDARD_PORT_VARIANT_2) :             // RULE_18
    (pins == 3'h6) ? charge_port_pkg::MODE_STANDARD_PORT_VARIANT_4 :               // RULE_18
    (pins == 3'h2) ? charge_port_pkg::MODE_STANDARD_PORT_VARIANT_1 :               // RULE_18
    (pins == 3'h4) ? charge_port_pkg::MODE_SHORTED :            // RULE_18
    (pins == 3'h5) ? charge_port_pkg::MODE_DIVIDER :            // RULE_18
    charge_port_pkg::MODE_AUTO;                                  // RULE_18

  // state reached when a mode is applied without a discharge
  wire pin_is_data = (pin_mode == charge_port_pkg::MODE_CDP) ||
                     (pin_mode == charge_port_pkg::MODE_STANDARD_PORT_VARIANT_2) ||
                     (pin_mode == charge_port_pkg::MODE_STANDARD_PORT_VARIANT_4) ||
                     (pin_mode == charge_port_pkg::MODE_STANDARD_PORT_VARIANT_1);
  assign entry_state =
    (pin_mode == charge_port_pkg::MODE_DISCHARGE) ?
      charge_port_pkg::ST_HOLD_LOW :
    pin_is_data ? charge_port_pkg::ST_DATA :
    (pin_mode == charge_port_pkg::MODE_SHORTED) ?
      charge_port_pkg::ST_FORCED_SHORT :                         // RULE_11
    (pin_mode == charge_port_pkg::MODE_DIVIDER) ?
      charge_port_pkg::ST_FORCED_DIV :                           // RULE_11
    charge_port_pkg::ST_DIV_A;                                   // RULE_06

  // mode change classification
  wire mode_change = (pin_mode != mode_reg);
  wire reg_cdp_standard_port_variant_2 = (mode_reg == charge_port_pkg::MODE_CDP) ||
                      (mode_reg == charge_port_pkg::MODE_STANDARD_PORT_VARIANT_2);
  wire pin_cdp_standard_port_variant_2 = (pin_mode == charge_port_pkg::MODE_CDP) ||
                      (pin_mode == charge_port_pkg::MODE_STANDARD_PORT_VARIANT_2);
  wire quiet_swap = reg_cdp_standard_port_variant_2 && pin_cdp_standard_port_variant_2;               // RULE_19
  wire from_data_mode = reg_cdp_standard_port_variant_2 ||
                        (mode_reg == charge_port_pkg::MODE_STANDARD_PORT_VARIANT_1);
  wire use_long = from_data_mode &&
                  (pin_mode == charge_port_pkg::MODE_AUTO);      // RULE_21
  wire timer_done = (timer_reg == TIMER_ZERO);
  wire [TIMER_W-1:0] timer_dec = timer_done ? TIMER_ZERO :
                                 timer_reg - TIMER_W'(1);

  // main controller; pin changes override any auto-detect step
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    timer_next = timer_dec;
    disch_req_clr = 1'b0;
    case (state_reg)
      charge_port_pkg::ST_INIT: begin
        state_next = entry_state;                                // RULE_17
        mode_next = pin_mode;                                    // RULE_17
      end
      charge_port_pkg::ST_HOLD_LOW: begin
        // output already drained, so leaving needs no new discharge
        if (mode_change) begin
          state_next = entry_state;
          mode_next = pin_mode;
        end
      end
      charge_port_pkg::ST_DISCHARGE: begin
        if (timer_done) begin
          state_next = entry_state;                              // RULE_20
          mode_next = pin_mode;
        end
      end
      default: begin
        if (mode_change) begin
          mode_next = pin_mode;
          if (pin_mode == charge_port_pkg::MODE_DISCHARGE) begin
            state_next = charge_port_pkg::ST_HOLD_LOW;
          end else if (quiet_swap) begin
            state_next = entry_state;                            // RULE_19
          end else begin
            state_next = charge_port_pkg::ST_DISCHARGE;          // RULE_19
            timer_next = use_long ? LONG_LOAD : SHORT_LOAD;      // RULE_21
          end
        end else if (disch_req_reg) begin
          disch_req_clr = 1'b1;
          state_next = charge_port_pkg::ST_DISCHARGE;            // RULE_20
          timer_next = SHORT_LOAD;
        end else begin
          case (state_reg)
            charge_port_pkg::ST_DIV_A: begin // RULE_08
              // attach of a shorted-scheme device outranks current draw
              if (device_on_lines_i) begin
                state_next = charge_port_pkg::ST_ATTACH_DISCH;   // RULE_06
                timer_next = SHORT_LOAD;
              end else if (high_current_i) begin
                state_next = charge_port_pkg::ST_DIV_B;          // RULE_09
                timer_next = RETEST_LOAD;
              end
            end
            charge_port_pkg::ST_DIV_B: begin
              if (device_on_lines_i) begin
                state_next = charge_port_pkg::ST_ATTACH_DISCH;   // RULE_06
                timer_next = SHORT_LOAD;
              end else if (timer_done) begin
                if (high_current_i) begin
                  timer_next = RETEST_LOAD;                      // RULE_10
                end else begin
                  state_next = charge_port_pkg::ST_DIV_A;        // RULE_10
                end
              end
            end
            charge_port_pkg::ST_ATTACH_DISCH: begin
              if (timer_done) begin
                state_next = charge_port_pkg::ST_PULL_1V2;       // RULE_06
                timer_next = PULL_LOAD;
              end
            end
            charge_port_pkg::ST_PULL_1V2: begin
              if (timer_done) begin
                state_next = charge_port_pkg::ST_AUTO_SHORT;     // RULE_05
              end
            end
            charge_port_pkg::ST_AUTO_SHORT: begin
              if (!device_on_lines_i) begin
                state_next = charge_port_pkg::ST_DIV_A;          // RULE_07
              end
            end
            default: begin
              // forced and data modes have no automatic steps
              state_next = state_reg;                            // RULE_11
            end
          endcase
        end
      end
    endcase
  end

  // line and switch controls, taken from the next state so they
  // change on the same edge as the state itself
  wire discharging_next =
    (state_next == charge_port_pkg::ST_INIT) ||
    (state_next == charge_port_pkg::ST_HOLD_LOW) ||
    (state_next == charge_port_pkg::ST_DISCHARGE) ||
    (state_next == charge_port_pkg::ST_ATTACH_DISCH);
  // current_limit_active_i deliberately plays no part here
  wire data_sw_next = enable_i && // RULE_15
                      (state_next == charge_port_pkg::ST_DATA);  // RULE_12
  wire power_next = enable_i && !discharging_next;               // RULE_20
  wire shorted_next =
    (state_next == charge_port_pkg::ST_FORCED_SHORT) ||
    (state_next == charge_port_pkg::ST_AUTO_SHORT) ||
    (state_next == charge_port_pkg::ST_PULL_1V2);                // RULE_03
  wire pull_next = (state_next == charge_port_pkg::ST_PULL_1V2); // RULE_05
  wire div_a_next = (state_next == charge_port_pkg::ST_FORCED_DIV) ||
                    (state_next == charge_port_pkg::ST_DIV_A);   // RULE_04
  wire div_b_next = (state_next == charge_port_pkg::ST_DIV_B);   // RULE_04
  wire unused_limit = current_limit_active_i;                    // RULE_14

  // state and timer; reset lands in the initial discharging state
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= charge_port_pkg::ST_INIT;                     // RULE_17
      mode_reg <= charge_port_pkg::MODE_DISCHARGE;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      timer_reg <= timer_next;
    end
  end

  // registered outputs; data switches stay open through any discharge
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_reg <= 1'b0;
      disch_out_reg <= 1'b1;                                     // RULE_17
      data_sw_reg <= 1'b0;                                       // RULE_16
      shorted_reg <= 1'b0;
      pull_reg <= 1'b0;
      div_a_reg <= 1'b0;
      div_b_reg <= 1'b0;
    end else begin
      power_reg <= power_next;
      disch_out_reg <= discharging_next;                         // RULE_20
      data_sw_reg <= data_sw_next && !discharging_next; // RULE_13 RULE_16
      shorted_reg <= shorted_next;
      pull_reg <= pull_next;
      div_a_reg <= div_a_next;
      div_b_reg <= div_b_next;
    end
  end

  // avalon slave: every access waits exactly one cycle
  wire bus_req = avs_read_i || avs_write_i;
  wire bus_take = bus_req && !wait_reg;
  wire ctrl_write = avs_write_i && bus_take &&
                    (avs_address_i == charge_port_pkg::CONTROL_ADDR);
  // software set wins over the hardware clear in the same cycle
  assign disch_req_next =
    (ctrl_write && avs_writedata_i[charge_port_pkg::CTRL_DISCHARGE_BIT]) ||
    (disch_req_reg && !disch_req_clr);

  // status word; unmapped addresses read as zero
  wire [31:0] status_word =
    (32'(state_reg) << charge_port_pkg::STAT_STATE_LSB) |
    (32'(mode_reg) << charge_port_pkg::STAT_MODE_LSB) |
    (32'(disch_out_reg) << charge_port_pkg::STAT_DISCH_BIT) |
    (32'(data_sw_reg) << charge_port_pkg::STAT_DATA_BIT) |
    (32'(power_reg) << charge_port_pkg::STAT_POWER_BIT);
  wire [31:0] read_mux =
    (avs_address_i == charge_port_pkg::STATUS_ADDR) ? status_word :
    (avs_address_i == charge_port_pkg::CONTROL_ADDR) ?
      (32'(disch_req_reg) << charge_port_pkg::CTRL_DISCHARGE_BIT) :
    32'h00000000;

  // bus handshake and control flag
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      disch_req_reg <= 1'b0;
    end else begin
      wait_reg <= !(bus_req && wait_reg);
      if (avs_read_i && wait_reg) begin
        rdata_reg <= read_mux;
      end
      disch_req_reg <= disch_req_next;
    end
  end

  assign avs_readdata_o = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign power_switch_on_o = power_reg;
  assign out_discharge_o = disch_out_reg;
  assign data_switch_on_o = data_sw_reg;
  assign lines_shorted_o = shorted_reg;
  assign pull_1v2_o = pull_reg;
  assign divider_a_o = div_a_reg;
  assign divider_b_o = div_b_reg;

endmodule : charge_port_ctrl

// *** rtl/charge_port_pkg.sv ***
// Functional notes
// RULE_01: portable device drives D+ near 0.6 V, reads D- to spot SDP.
// RULE_02: portable device drives D- near 0.6 V, reads D+ for CDP or DCP.
// RULE_03: shorted scheme ties D+ to D- through at most 200 ohms.
// RULE_04: divider scheme a puts 2 V/2.7 V on D+/D-; scheme b swaps.
// RULE_05: 1.2 V scheme shorts and pulls lines up, then enters shorted.
// RULE_06: auto detect starts in divider a; attach runs discharge, 1.2 V, shorted.
// RULE_07: auto shorted holds until device releases lines, then divider a.
// RULE_08: divider a compliant device keeps the machine in divider a.
// RULE_09: divider a moves to divider b when current exceeds 750 mA.
// RULE_10: divider b retests high current; stays if drawn, else divider a.
// RULE_11: forced modes hold one scheme chosen by pins, never changing.
// RULE_12: data switches closed in CDP and SDP modes only with enable high.
// RULE_13: switches open on enable low, pins 000, or any charger mode.
// RULE_14: current limit never opens the data switches.
// RULE_15: CDP keeps data switches closed throughout, handshake included.
// RULE_16: data switches open while any output discharge runs.
// RULE_17: reset holds initial discharging state; release follows the pins.
// RULE_18: mode pins bit1 bit2 bit3 decode per mode table.
// RULE_19: variant 2 and CDP swap quietly; other charging changes discharge.
// RULE_20: discharge turns switch off, drains output, then switches back on.
// RULE_21: long time into auto detect from data modes, short time back; code uses the short time from variant 4 into auto.
// RULE_22: undocumented durations are cycle-count parameters.
package charge_port_pkg;

  localparam int CLK_PERIOD_NS = 5;
  // durations are not specified; plain defaults, overridable per instance
  localparam int LONG_DISCHARGE_NS = 10000;
  localparam int SHORT_DISCHARGE_NS = 2000;
  localparam int SCHEME_1V2_NS = 5000;
  localparam int RETEST_NS = 20000;
  localparam int LONG_DISCHARGE_CYC =
    (LONG_DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_DISCHARGE_CYC =
    (SHORT_DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCHEME_1V2_CYC =
    (SCHEME_1V2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETEST_CYC = (RETEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_WIDTH = 16;

  // register map, byte addresses on the avalon slave
  localparam logic [3:0] STATUS_ADDR = 4'h0;
  localparam logic [3:0] CONTROL_ADDR = 4'h4;
  localparam int CTRL_DISCHARGE_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_DISCH_BIT = 7;
  localparam int STAT_DATA_BIT = 8;
  localparam int STAT_POWER_BIT = 9;

  typedef enum logic [2:0] {
    MODE_DISCHARGE = 3'h0,
    MODE_CDP = 3'h1,
    MODE_STANDARD_PORT_VARIANT_2 = 3'h2,
    MODE_STANDARD_PORT_VARIANT_4 = 3'h3,
    MODE_STANDARD_PORT_VARIANT_1 = 3'h4,
    MODE_SHORTED = 3'h5,
    MODE_DIVIDER = 3'h6,
    MODE_AUTO = 3'h7
  } port_mode_t;

  typedef enum logic [3:0] {
    ST_INIT = 4'h0,
    ST_HOLD_LOW = 4'h1,
    ST_DISCHARGE = 4'h2,
    ST_DATA = 4'h3,
    ST_FORCED_SHORT = 4'h4,
    ST_FORCED_DIV = 4'h5,
    ST_DIV_A = 4'h6,
    ST_DIV_B = 4'h7,
    ST_ATTACH_DISCH = 4'h8,
    ST_PULL_1V2 = 4'h9,
    ST_AUTO_SHORT = 4'hA
  } ctrl_state_t;

endpackage : charge_port_pkg

// *** tb/portable_dev.sv ***
module portable_dev (
  input wire logic clock_i,
  input wire logic lines_shorted_i,
  input wire logic divider_i,
  input wire logic attach_i,
  input wire logic draw_i,
  output logic device_on_lines_o,
  output logic high_current_o,
  output logic saw_charger_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // the probe echoes across a short, so the device reads a charging port
  always_ff @(posedge clock_i) begin
    saw_charger_o <= lines_shorted_i;
    device_on_lines_o <= attach_i; // holds the data line while attached
    high_current_o <= draw_i && divider_i; // draws hard only on a divider
  end
endmodule : portable_dev

// *** tb/charge_port_ctrl_properties.sv ***
module charge_port_ctrl_checker (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic mode_select_bit1_i,
  input wire logic mode_select_bit2_i,
  input wire logic mode_select_bit3_i,
  input wire logic current_limit_select_i,
  input wire logic enable_i,
  input wire logic device_on_lines_i,
  input wire logic current_limit_active_i,
  input wire logic avs_write_i,
  input wire logic power_switch_on_o,
  input wire logic out_discharge_o,
  input wire logic data_switch_on_o,
  input wire logic lines_shorted_o,
  input wire logic pull_1v2_o,
  input wire logic divider_a_o,
  input wire logic divider_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // a bus write may request a discharge, so quiet checks exclude it
  wire [2:0] pins = {mode_select_bit1_i, mode_select_bit2_i, mode_select_bit3_i};
  wire auto_pins = !mode_select_bit1_i && mode_select_bit3_i;
  wire charger = lines_shorted_o || pull_1v2_o || divider_a_o || divider_b_o;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  dis_data_off_a: assert property (out_discharge_o |-> !data_switch_on_o)
    else $error("data switch closed during discharge");
  dis_power_off_a: assert property (out_discharge_o |-> !power_switch_on_o)
    else $error("power switch on during discharge");
  en_low_open_a: assert property (!enable_i ##1 !enable_i |-> !data_switch_on_o)
    else $error("data switch closed with enable low");
  charger_open_a: assert property (charger |-> !data_switch_on_o)
    else $error("data switch closed in charger scheme");
  pins_zero_a: assert property ((pins == 3'h0) ##1 (pins == 3'h0) |->
    out_discharge_o && !data_switch_on_o) else $error("pins 000 not held low");
  pull_short_a: assert property (pull_1v2_o |-> lines_shorted_o && !divider_a_o)
    else $error("1.2 V step without short");
  divider_excl_a: assert property (divider_a_o |-> !divider_b_o && !lines_shorted_o)
    else $error("divider schemes overlap");
  forced_hold_a: assert property ((pins == 3'h4 && lines_shorted_o && !avs_write_i
    && !$past(avs_write_i)) ##1 (pins == 3'h4 && !avs_write_i) |-> lines_shorted_o)
    else $error("forced short lost");
  auto_release_a: assert property ((auto_pins && $stable(pins) && lines_shorted_o
    && !pull_1v2_o && !device_on_lines_i && !avs_write_i && !$past(avs_write_i))
    |=> divider_a_o) else $error("released line did not return to divider a");
  quiet_swap_a: assert property ((pins == 3'h7 && $stable(pins) && !avs_write_i
    && !$past(avs_write_i) && $changed(current_limit_select_i) && data_switch_on_o)
    |=> !out_discharge_o [*2])
    else $error("discharge on cdp and variant 2 swap");
  limit_keep_a: assert property ((data_switch_on_o && enable_i && current_limit_active_i
    && $stable(pins) && $stable(current_limit_select_i) && !avs_write_i
    && !$past(avs_write_i)) |=> data_switch_on_o) else $error("current limit opened switch");
  short_after_a: assert property (($fell(pull_1v2_o) && auto_pins && $stable(pins))
    |-> lines_shorted_o) else $error("1.2 V step not followed by short");
  cover property ($rose(pull_1v2_o));
  cover property ($rose(divider_b_o));
  cover property ($fell(out_discharge_o) && divider_a_o);
endmodule : charge_port_ctrl_checker

bind charge_port_ctrl charge_port_ctrl_checker i_chk (.clock_i, .arst_n_i,
  .mode_select_bit1_i, .mode_select_bit2_i, .mode_select_bit3_i,
  .current_limit_select_i, .enable_i, .device_on_lines_i,
  .current_limit_active_i, .avs_write_i, .power_switch_on_o, .out_discharge_o,
  .data_switch_on_o, .lines_shorted_o, .pull_1v2_o, .divider_a_o, .divider_b_o);

// *** tb/charge_port_ctrl_tb.sv ***
module charge_port_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LONG = 12;
  localparam int SHORT = 4;
  localparam int P12 = 6;
  localparam int RETEST = 10;
  logic clock_i = 1'b0, arst_n_i, ilim, en, clim, attach, draw, rd_i, wr_i;
  logic [2:0] pins;
  logic [3:0] addr;
  logic [31:0] wd, rd, rdata;
  logic waitreq, power, disch, data_sw, shorted, pull, div_a, div_b;
  logic dev_on, hi_cur, saw;
  int fail_count = 0, cmp_count = 0, n, m, seed;
  int q[$];
  // short durations keep the run brief; expectations use the same values
  charge_port_ctrl #(.LONG_DISCHARGE_CYCLES(LONG), .SHORT_DISCHARGE_CYCLES(SHORT),
    .SCHEME_1V2_CYCLES(P12), .RETEST_CYCLES(RETEST)) i_dut (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .mode_select_bit1_i(pins[2]),
    .mode_select_bit2_i(pins[1]), .mode_select_bit3_i(pins[0]),
    .current_limit_select_i(ilim), .enable_i(en), .high_current_i(hi_cur),
    .device_on_lines_i(dev_on), .current_limit_active_i(clim),
    .avs_address_i(addr), .avs_read_i(rd_i), .avs_write_i(wr_i),
    .avs_writedata_i(wd), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .power_switch_on_o(power), .out_discharge_o(disch),
    .data_switch_on_o(data_sw), .lines_shorted_o(shorted), .pull_1v2_o(pull),
    .divider_a_o(div_a), .divider_b_o(div_b));
  portable_dev i_dev (.clock_i(clock_i), .lines_shorted_i(shorted),
    .divider_i(div_a || div_b), .attach_i(attach), .draw_i(draw),
    .device_on_lines_o(dev_on), .high_current_o(hi_cur), .saw_charger_o(saw));
  always #2.5 clock_i = ~clock_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // reference decode of the mode pins into the mode encoding
  function automatic int mode_of(input logic [2:0] p, input logic il);
    case (p)
      3'h0: return 0;
      3'h7: return il ? 1 : 2;
      3'h6: return 3;
      3'h2: return 4;
      3'h4: return 5;
      3'h5: return 6;
      default: return 7;
    endcase
  endfunction : mode_of
  task automatic set_mode(input logic [2:0] p, input logic il);
    @(posedge clock_i);
    pins <= p;
    ilim <= il;
  endtask : set_mode
  // request stands until waitrequest is sampled low at a rising edge;
  // read data is taken at that edge, only the watchdog ends a hang
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wd <= d;
    rd_i <= !we;
    wr_i <= we;
    do @(posedge clock_i); while (waitreq !== 1'b0);
    rd = rdata;
    rd_i <= 1'b0;
    wr_i <= 1'b0;
  endtask : bus
  // waits briefly for a discharge to start, then counts its cycles
  task automatic disch_len(output int len);
    int t;
    len = 0;
    t = 0;
    do begin @(negedge clock_i); t++; end while (disch !== 1'b1 && t < 8);
    while (disch === 1'b1 && len < 500) begin len++; @(negedge clock_i); end
  endtask : disch_len
  task automatic chk_len(input int exp);
    disch_len(n);
    check(32'(n >= exp && n <= exp + 1), 32'h1);
  endtask : chk_len
  initial begin
    seed = 32'h26DCDC42;
    {arst_n_i, ilim, en, clim, attach, draw, rd_i, wr_i} = 8'h20;
    pins = 3'h0;
    addr = 4'h0;
    wd = 32'h0;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    check(32'({disch, power, data_sw, waitreq}), 32'h9);
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    // every pin code entered from hold-low, enable and limit at random
    for (int i = 0; i < 16; i++) begin
      set_mode(3'h0, 1'b0);
      repeat (3) @(posedge clock_i);
      en <= 1'($random(seed));
      clim <= 1'($random(seed));
      set_mode(3'(i >> 1), 1'(i));
      q.push_back(mode_of(3'(i >> 1), 1'(i)));
      repeat (3) @(posedge clock_i);
      bus(1'b0, 4'h0, 32'h0);
      m = q.pop_front();
      check(32'(rd[6:4]), 32'(m));
      check(32'(data_sw), 32'(en && m >= 1 && m <= 4));
      check(32'(shorted), 32'(m == 5));
      check(32'(div_a), 32'(m >= 6));
    end
    en <= 1'b1;
    // leaving cdp for variant 1 discharges; let it finish before auto
    set_mode(3'h2, 1'b0);
    chk_len(SHORT);
    set_mode(3'h3, 1'b0);
    chk_len(LONG);
    check(32'({div_a, power}), 32'h3);
    set_mode(3'h2, 1'b0);
    chk_len(SHORT);
    set_mode(3'h7, 1'b1);
    chk_len(SHORT);
    check(32'(data_sw), 32'h1);
    set_mode(3'h7, 1'b0);
    clim <= 1'b1;
    disch_len(n);
    check(32'(n), 32'h0);
    check(32'(data_sw), 32'h1);
    set_mode(3'h6, 1'b0);
    chk_len(SHORT);
    set_mode(3'h3, 1'b0);
    chk_len(SHORT);
    repeat (20) @(posedge clock_i);
    check(32'(div_a), 32'h1);
    draw <= 1'b1;
    repeat (4) @(posedge clock_i);
    check(32'(div_b), 32'h1);
    repeat (RETEST + 3) @(posedge clock_i);
    check(32'(div_b), 32'h1);
    draw <= 1'b0;
    repeat (2 * RETEST + 3) @(posedge clock_i);
    check(32'(div_a), 32'h1);
    attach <= 1'b1;
    chk_len(SHORT);
    check(32'({pull, shorted, power}), 32'h7);
    repeat (P12 + 3) @(posedge clock_i);
    check(32'({pull, shorted, saw}), 32'h3);
    attach <= 1'b0;
    repeat (4) @(posedge clock_i);
    check(32'(div_a), 32'h1);
    // discharge on request, unmapped read, ignored write to status
    set_mode(3'h2, 1'b0);
    disch_len(n);
    bus(1'b1, 4'h4, 32'h1);
    chk_len(SHORT);
    bus(1'b0, 4'hC, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'h0, 32'hFFFFFFFF);
    bus(1'b0, 4'h0, 32'h0);
    check(32'(rd[6:4]), 32'h4);
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    @(negedge clock_i);
    check(32'({disch, data_sw}), 32'h2);
    @(posedge clock_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    check(32'(data_sw), 32'h1);
    finish_test();
  end
  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    finish_test();
  end
endmodule : charge_port_ctrl_tb
